/* rtl/acr_map.svh */
// constants shared by both ends of the converter readout link
`ifndef ACR_MAP_SVH
`define ACR_MAP_SVH

`define ACR_CLK_NS           5
`define ACR_RES_BITS         8

// conversion: longest time, rounded down
`define ACR_CONV_TIME_NS     7500
`define ACR_CONV_CYC         (`ACR_CONV_TIME_NS / `ACR_CLK_NS)
`define ACR_CONV_MARGIN_CYC  16

// data release after the last rising shift edge: least time, rounded up
`define ACR_TCHZ_MIN_NS      100
`define ACR_TCHZ_CYC         ((`ACR_TCHZ_MIN_NS + `ACR_CLK_NS - 1) / `ACR_CLK_NS)

// convert-start high time and last-shift-edge to next start: least times
`define ACR_TCSH_MIN_NS      50
`define ACR_TCSH_CYC         ((`ACR_TCSH_MIN_NS + `ACR_CLK_NS - 1) / `ACR_CLK_NS)
`define ACR_TCCS_MIN_NS      50
`define ACR_TCCS_CYC         ((`ACR_TCCS_MIN_NS + `ACR_CLK_NS - 1) / `ACR_CLK_NS)

// shift clock half period for 5 MHz
`define ACR_SCLK_HALF_NS     100
`define ACR_SCLK_HALF_CYC    ((`ACR_SCLK_HALF_NS + `ACR_CLK_NS - 1) / `ACR_CLK_NS)

`endif

/* rtl/acr_pkg.sv */
// state types of both link ends
package acr_pkg;

    typedef enum logic [1:0] {
        DEV_SHUT    = 2'b00,
        DEV_CONV    = 2'b01,
        DEV_READY   = 2'b10,
        DEV_RELEASE = 2'b11
    } acr_dev_state_t;

    typedef enum logic [2:0] {
        HST_IDLE  = 3'b000,
        HST_HIGH1 = 3'b001,
        HST_LOW1  = 3'b010,
        HST_HIGH2 = 3'b011,
        HST_WAIT  = 3'b100,
        HST_SHIFT = 3'b101,
        HST_PUSH  = 3'b110,
        HST_GAP   = 3'b111
    } acr_host_state_t;

endpackage

/* rtl/acr_link_if.sv */
// three-wire link between the serial master and the converter
interface acr_link_if;
    logic convert_start_n;
    logic sclk;
    logic dout_o;
    logic dout_oe;
    logic dout_line;

    // released line reads high, as with a weak pull-up
    assign dout_line = dout_oe ? dout_o : 1'b1;

    modport dev (
        input  convert_start_n,
        input  sclk,
        output dout_o,
        output dout_oe
    );

    modport host (
        output convert_start_n,
        output sclk,
        input  dout_line
    );
endinterface

/* rtl/acr_buf2.sv */
// two-entry result buffer with registered head
module acr_buf2 #(
    parameter int W     = 8,
    parameter int DEPTH = 2
) (
    // system
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid_ff,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data_ff
);
    if (DEPTH != 2 || W < 1) begin : g_bad_cfg
        $error("acr_buf2: only DEPTH 2 and W >= 1 are built");
    end

    logic         tail_v_ff;
    logic [W-1:0] tail_ff;
    logic         push;

    // head register feeds the port directly, tail holds the spare word
    assign in_ready = ~tail_v_ff;
    assign push     = in_valid & in_ready;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            out_valid_ff <= 1'b0;
            out_data_ff  <= '0;
            tail_v_ff    <= 1'b0;
            tail_ff      <= '0;
        end else if (!out_valid_ff || out_ready) begin
            if (tail_v_ff) begin
                out_valid_ff <= 1'b1;
                out_data_ff  <= tail_ff;
                tail_v_ff    <= 1'b0;
            end else begin
                out_valid_ff <= push;
                if (push) begin
                    out_data_ff <= in_data;
                end
            end
        end else if (push) begin
            tail_v_ff <= 1'b1;
            tail_ff   <= in_data;
        end
    end
endmodule

/* rtl/acr_device.sv */
// converter end: start detection, successive approximation and serial readout
`include "acr_map.svh"
//
// Notes on behaviour
// - shift clock up to 5 MHz shifts correctly
// - works with shift clock idling low or high
// - host uses polarity equal to phase
// - falling start edge samples the input
// - start rests either level; high pulse 50 ns
// - second start pulse selects mid-supply input
// - host waits 7.5 us before reading
// - data line low throughout a conversion
// - msb appears as soon as conversion ends
// - result is unsigned straight binary
// - falling shift edge advances, msb first
// - release line 100-500 ns after eighth rise
// - shift clock ignored while converting
// - start fall mid-conversion aborts, selects mid-supply
// - host reads all bits before new conversion
// - completion enters shutdown until next start
// - only high-to-low start edge starts conversion
// - last result held through shutdown
// - one lsb is reference over 256
// - host keeps 50 ns after last shift
module acr_device #(
    parameter int RES_W    = `ACR_RES_BITS,
    parameter int CONV_CYC = `ACR_CONV_CYC,
    parameter int TCHZ_CYC = `ACR_TCHZ_CYC
) (
    // system
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // serial link
    acr_link_if.dev               link,
    // sampled input
    input  wire logic [RES_W-1:0] analog_channel_in,
    // status
    output logic                  conv_busy_ff,
    output logic                  shutdown_ff,
    output logic                  mid_sel_ff,
    output logic                  result_done_ff,
    output logic [RES_W-1:0]      last_result_ff
);
    localparam int CW       = 16;
    localparam int BW       = $clog2(RES_W + 1);
    localparam int STEP_CYC = (CONV_CYC - 8) / RES_W;
    localparam logic [RES_W-1:0] MID_CODE = {1'b1, {(RES_W - 1){1'b0}}};

    if (RES_W < 2 || RES_W > 16) begin : g_bad_width
        $error("acr_device: RES_W must lie in 2..16");
    end
    if (STEP_CYC < 1 || CONV_CYC >= 65536 || TCHZ_CYC < 1 || TCHZ_CYC >= 65536) begin : g_bad_time
        $error("acr_device: conversion or release count out of range");
    end

    acr_pkg::acr_dev_state_t state_ff;
    acr_pkg::acr_dev_state_t nxt_state;

    logic [2:0]       cs_sync_ff;
    logic [2:0]       sck_sync_ff;
    logic             cs_fall;
    logic             sck_rise;
    logic             sck_fall;
    logic [CW-1:0]    cnt_ff;
    logic [BW-1:0]    bit_ff;
    logic [BW-1:0]    rise_cnt_ff;
    logic [RES_W-1:0] sample_ff;
    logic [RES_W-1:0] approx_ff;
    logic [RES_W-1:0] shift_ff;
    logic [RES_W-1:0] trial;
    logic [RES_W-1:0] nxt_approx;
    logic             step_end;
    logic             conv_end;
    logic             dout_ff;
    logic             dout_oe_ff;

    // ------------------------------------------------------------------
    // link inputs: two stages, then a third for edge finding.
    // a 5 MHz shift clock leaves 20 system cycles per half period, so the
    // three-cycle sampling delay never merges two edges.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            // low at reset: a start line already low at power-up gives no edge
            cs_sync_ff  <= 3'h0;
            sck_sync_ff <= 3'h0;
        end else begin
            cs_sync_ff  <= {cs_sync_ff[1:0], link.convert_start_n};
            sck_sync_ff <= {sck_sync_ff[1:0], link.sclk};
        end
    end

    assign cs_fall  = cs_sync_ff[2] & ~cs_sync_ff[1];
    assign sck_rise = ~sck_sync_ff[2] & sck_sync_ff[1];
    assign sck_fall = sck_sync_ff[2] & ~sck_sync_ff[1];

    // ------------------------------------------------------------------
    // successive approximation: one bit per step, msb first
    // ------------------------------------------------------------------
    assign step_end   = (cnt_ff == CW'(STEP_CYC - 1));
    assign conv_end   = (state_ff == acr_pkg::DEV_CONV) && step_end && (bit_ff == '0) && !cs_fall;
    assign trial      = approx_ff | (RES_W'(1) << bit_ff);
    // the code counts lsb steps of the reference divided by 2**RES_W
    assign nxt_approx = (trial <= sample_ff) ? trial : approx_ff;

    // ------------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            acr_pkg::DEV_SHUT: begin
                if (cs_fall) begin
                    nxt_state = acr_pkg::DEV_CONV;
                end
            end
            acr_pkg::DEV_CONV: begin
                // a fall here restarts the conversion and stays in this state
                if (conv_end) begin
                    nxt_state = acr_pkg::DEV_READY;
                end
            end
            acr_pkg::DEV_READY: begin
                if (cs_fall) begin
                    nxt_state = acr_pkg::DEV_CONV;
                end else if (rise_cnt_ff == BW'(RES_W)) begin
                    nxt_state = acr_pkg::DEV_RELEASE;
                end
            end
            acr_pkg::DEV_RELEASE: begin
                if (cs_fall) begin
                    nxt_state = acr_pkg::DEV_CONV;
                end else if (cnt_ff == CW'(TCHZ_CYC - 1)) begin
                    nxt_state = acr_pkg::DEV_SHUT;
                end
            end
            default: begin
                nxt_state = acr_pkg::DEV_SHUT;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_ff     <= acr_pkg::DEV_SHUT;
            conv_busy_ff <= 1'b0;
            shutdown_ff  <= 1'b1;
        end else begin
            state_ff     <= nxt_state;
            conv_busy_ff <= (nxt_state == acr_pkg::DEV_CONV);
            // analog part is powered only while converting
            shutdown_ff  <= (nxt_state != acr_pkg::DEV_CONV);
        end
    end

    // step and release timer
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt_ff <= '0;
        end else if (cs_fall || (nxt_state != state_ff) ||
                     (state_ff == acr_pkg::DEV_CONV && step_end)) begin
            cnt_ff <= '0;
        end else if (state_ff == acr_pkg::DEV_CONV || state_ff == acr_pkg::DEV_RELEASE) begin
            cnt_ff <= cnt_ff + CW'(1);
        end
    end

    // sample, approximation and holding register
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sample_ff      <= '0;
            approx_ff      <= '0;
            bit_ff         <= '0;
            mid_sel_ff     <= 1'b0;
            result_done_ff <= 1'b0;
            last_result_ff <= '0;
        end else begin
            result_done_ff <= 1'b0;
            if (cs_fall) begin
                // a second pulse lands inside the conversion it started, so the
                // abort path is also the way to pick the mid-supply input
                mid_sel_ff <= (state_ff == acr_pkg::DEV_CONV);
                sample_ff  <= (state_ff == acr_pkg::DEV_CONV) ?
                              MID_CODE : analog_channel_in;
                approx_ff  <= '0;
                bit_ff     <= BW'(RES_W - 1);
            end else if (state_ff == acr_pkg::DEV_CONV && step_end) begin
                approx_ff <= nxt_approx;
                bit_ff    <= bit_ff - BW'(1);
                if (bit_ff == '0) begin
                    // kept until the next completion, across shutdown
                    last_result_ff <= nxt_approx;
                    result_done_ff <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // readout shifter. a falling edge shifts only after a rising edge has
    // been seen, so an idle-high clock's leading fall keeps the msb.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            shift_ff    <= '0;
            rise_cnt_ff <= '0;
        end else if (conv_end) begin
            shift_ff    <= nxt_approx;
            rise_cnt_ff <= '0;
        end else if (state_ff == acr_pkg::DEV_READY) begin
            // edges outside this state, conversion included, are dropped
            if (sck_rise) begin
                rise_cnt_ff <= rise_cnt_ff + BW'(1);
            end
            if (sck_fall && rise_cnt_ff != '0) begin
                shift_ff <= {shift_ff[RES_W-2:0], 1'b0};
            end
        end
    end

    // data pin, one cycle behind the state; well inside the enable time
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            dout_ff    <= 1'b0;
            dout_oe_ff <= 1'b0;
        end else begin
            dout_oe_ff <= (state_ff != acr_pkg::DEV_SHUT);
            if (state_ff == acr_pkg::DEV_READY || state_ff == acr_pkg::DEV_RELEASE) begin
                dout_ff <= shift_ff[RES_W-1];
            end else begin
                dout_ff <= 1'b0;
            end
        end
    end

    assign link.dout_o  = dout_ff;
    assign link.dout_oe = dout_oe_ff;
endmodule

/* rtl/acr_host.sv */
// serial master end: start pulses, shift clock and result assembly
`include "acr_map.svh"
module acr_host #(
    parameter int RES_W    = `ACR_RES_BITS,
    parameter int HALF_CYC = `ACR_SCLK_HALF_CYC,
    parameter int CSH_CYC  = `ACR_TCSH_CYC,
    parameter int CCS_CYC  = `ACR_TCCS_CYC,
    parameter int WAIT_CYC = `ACR_CONV_CYC + `ACR_CONV_MARGIN_CYC
) (
    // system
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // serial link
    acr_link_if.host              link,
    // command
    input  wire logic             start,
    input  wire logic             start_mid,
    input  wire logic             clk_idle_high,
    output logic                  busy_ff,
    // result stream
    output logic                  result_valid_ff,
    input  wire logic             result_ready,
    output logic [RES_W-1:0]      result_data_ff
);
    localparam int CW = 16;
    localparam int HW = $clog2(2 * RES_W + 1);

    if (RES_W < 2 || HALF_CYC < 4 || CSH_CYC < 1 || CCS_CYC < 1 ||
        WAIT_CYC >= 65536) begin : g_bad_cfg
        $error("acr_host: width or timing count out of range");
    end

    acr_pkg::acr_host_state_t state_ff;
    acr_pkg::acr_host_state_t nxt_state;

    logic [CW-1:0]    cnt_ff;
    logic [CW-1:0]    lim;
    logic [HW-1:0]    half_ff;
    logic             cnt_done;
    logic             last_half;
    logic             mid_ff;
    logic             cpol_ff;
    logic             cs_n_ff;
    logic             sclk_ff;
    logic [1:0]       dout_sync_ff;
    logic [RES_W-1:0] shreg_ff;
    logic             buf_in_ready;

    always_comb begin
        case (state_ff)
            acr_pkg::HST_HIGH1, acr_pkg::HST_LOW1, acr_pkg::HST_HIGH2: lim = CW'(CSH_CYC);
            acr_pkg::HST_WAIT:  lim = CW'(WAIT_CYC);
            acr_pkg::HST_SHIFT: lim = CW'(HALF_CYC);
            acr_pkg::HST_GAP:   lim = CW'(CCS_CYC);
            default:            lim = CW'(1);
        endcase
    end

    assign cnt_done  = (cnt_ff == lim - CW'(1));
    assign last_half = (half_ff == HW'(2 * RES_W - 1));

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            acr_pkg::HST_IDLE: begin
                // a full buffer holds off the next conversion
                if (start && buf_in_ready) begin
                    nxt_state = acr_pkg::HST_HIGH1;
                end
            end
            acr_pkg::HST_HIGH1: begin
                if (cnt_done) begin
                    nxt_state = mid_ff ? acr_pkg::HST_LOW1 : acr_pkg::HST_WAIT;
                end
            end
            acr_pkg::HST_LOW1: begin
                if (cnt_done) begin
                    nxt_state = acr_pkg::HST_HIGH2;
                end
            end
            acr_pkg::HST_HIGH2: begin
                if (cnt_done) begin
                    nxt_state = acr_pkg::HST_WAIT;
                end
            end
            acr_pkg::HST_WAIT: begin
                if (cnt_done) begin
                    nxt_state = acr_pkg::HST_SHIFT;
                end
            end
            acr_pkg::HST_SHIFT: begin
                // all bits are read before any new start
                if (cnt_done && last_half) begin
                    nxt_state = acr_pkg::HST_PUSH;
                end
            end
            acr_pkg::HST_PUSH: begin
                nxt_state = acr_pkg::HST_GAP;
            end
            default: begin
                if (cnt_done) begin
                    nxt_state = acr_pkg::HST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_ff <= acr_pkg::HST_IDLE;
            busy_ff  <= 1'b0;
            cnt_ff   <= '0;
            half_ff  <= '0;
        end else begin
            state_ff <= nxt_state;
            busy_ff  <= (nxt_state != acr_pkg::HST_IDLE);
            if (nxt_state != state_ff || (state_ff == acr_pkg::HST_SHIFT && cnt_done)) begin
                cnt_ff <= '0;
            end else begin
                cnt_ff <= cnt_ff + CW'(1);
            end
            if (state_ff != acr_pkg::HST_SHIFT) begin
                half_ff <= '0;
            end else if (cnt_done) begin
                half_ff <= half_ff + HW'(1);
            end
        end
    end

    // options are taken at the start and held for the whole transfer
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mid_ff  <= 1'b0;
            cpol_ff <= 1'b0;
        end else if (state_ff == acr_pkg::HST_IDLE) begin
            mid_ff  <= start_mid;
            cpol_ff <= clk_idle_high;
        end
    end

    // pins: the start line rests low after a transfer, so each start is a
    // high pulse of the least width followed by the fall
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cs_n_ff <= 1'b1;
            sclk_ff <= 1'b0;
        end else begin
            case (nxt_state)
                acr_pkg::HST_IDLE: cs_n_ff <= cs_n_ff;
                acr_pkg::HST_HIGH1, acr_pkg::HST_HIGH2: cs_n_ff <= 1'b1;
                default: cs_n_ff <= 1'b0;
            endcase
            // half periods alternate low, high from either idle level, so
            // polarity and phase are always equal
            sclk_ff <= (state_ff == acr_pkg::HST_SHIFT) ? half_ff[0] : cpol_ff;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            dout_sync_ff <= 2'h0;
            shreg_ff     <= '0;
        end else begin
            dout_sync_ff <= {dout_sync_ff[0], link.dout_line};
            // sample late in the high half, after the rising edge
            if (state_ff == acr_pkg::HST_SHIFT && cnt_done && half_ff[0]) begin
                shreg_ff <= {shreg_ff[RES_W-2:0], dout_sync_ff[1]};
            end
        end
    end

    assign link.convert_start_n = cs_n_ff;
    assign link.sclk            = sclk_ff;

    acr_buf2 #(
        .W     (RES_W),
        .DEPTH (2)
    ) u_buf (
        .clk_sys      (clk_sys),
        .rst_n        (rst_n),
        .in_valid     (state_ff == acr_pkg::HST_PUSH),
        .in_ready     (buf_in_ready),
        .in_data      (shreg_ff),
        .out_valid_ff (result_valid_ff),
        .out_ready    (result_ready),
        .out_data_ff  (result_data_ff)
    );
endmodule

/* verification/acr_link_properties.sv */
// assertions on the converter readout link wires
module acr_link_properties (
    // system
    input wire logic clk_sys,
    input wire logic rst_n,
    // link wires
    input wire logic convert_start_n,
    input wire logic sclk,
    input wire logic dout_o,
    input wire logic dout_oe,
    input wire logic dout_line
);
    logic       cs_q_ff;
    logic       sclk_q_ff;
    logic [3:0] rise_cnt_ff;
    logic [4:0] since_cs_ff;
    logic [4:0] since_fall_ff;
    logic       cs_fall;
    logic       sclk_rise;

    assign cs_fall   = cs_q_ff & ~convert_start_n;
    assign sclk_rise = ~sclk_q_ff & sclk;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    always_ff @(posedge clk_sys) begin
        cs_q_ff <= rst_n ? convert_start_n : 1'b1;
    end
    always_ff @(posedge clk_sys) begin
        sclk_q_ff <= sclk;
    end
    // counts wire rises; the device sees each one a few cycles later
    always_ff @(posedge clk_sys) begin
        if (!rst_n || cs_fall)
            rise_cnt_ff <= 4'h0;
        else if (sclk_rise && rise_cnt_ff != 4'hf)
            rise_cnt_ff <= rise_cnt_ff + 4'h1;
    end
    // saturating ages, so a reset reads as long ago
    always_ff @(posedge clk_sys) begin
        if (!rst_n)
            since_cs_ff <= 5'h1f;
        else if (cs_fall)
            since_cs_ff <= 5'h00;
        else if (since_cs_ff != 5'h1f)
            since_cs_ff <= since_cs_ff + 5'h01;
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n)
            since_fall_ff <= 5'h1f;
        else if (sclk_q_ff && !sclk)
            since_fall_ff <= 5'h00;
        else if (since_fall_ff != 5'h1f)
            since_fall_ff <= since_fall_ff + 5'h01;
    end

    property p_start_drive;
        $fell(convert_start_n) |-> ##[1:8] (dout_oe && !dout_line);
    endproperty
    a_start_drive: assert property (p_start_drive)
        else $error("data line not driven low after start fall");
    property p_conv_low;
        $fell(convert_start_n) ##8 1 |-> (dout_oe && !dout_line)[*8];
    endproperty
    a_conv_low: assert property (p_conv_low)
        else $error("data line left low state during conversion");
    property p_rose_cause;
        $rose(dout_oe) |-> since_cs_ff <= 5'h08;
    endproperty
    a_rose_cause: assert property (p_rose_cause)
        else $error("data line driven without a start fall");
    property p_oe_hold;
        dout_oe && rise_cnt_ff < 4'h8 |=> dout_oe;
    endproperty
    a_oe_hold: assert property (p_oe_hold)
        else $error("data line released before eighth rise");
    property p_shift_edge;
        dout_oe && $past(dout_oe) && $changed(dout_o) && rise_cnt_ff != 4'h0
            |-> since_fall_ff <= 5'h08;
    endproperty
    a_shift_edge: assert property (p_shift_edge)
        else $error("data bit changed without a falling shift edge");
    property p_bit_stable;
        dout_oe && sclk && sclk_q_ff && rise_cnt_ff != 4'h0 |-> $stable(dout_o);
    endproperty
    a_bit_stable: assert property (p_bit_stable)
        else $error("data bit changed while shift clock high");
    property p_release_min;
        sclk_rise && rise_cnt_ff == 4'h7 |-> (dout_oe throughout ##19 1) ##[1:80] !dout_oe;
    endproperty
    a_release_min: assert property (p_release_min)
        else $error("data line release outside its window");
    property p_release_fall;
        $fell(dout_oe) |-> rise_cnt_ff == 4'h8;
    endproperty
    a_release_fall: assert property (p_release_fall)
        else $error("data line released at wrong bit count");
endmodule

/* verification/tb_adc_convert_serial_readout.sv */
// self-checking bench joining both link ends
`define TB_CHK(what, exp, got) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            error_cnt++; \
            $display("mismatch %s expected %h seen %h", what, exp, got); \
        end \
    end
module tb_adc_convert_serial_readout;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk_sys = 1'b0;
    logic       rst_n, start, start_mid, clk_idle_high, result_ready;
    logic       busy_ff, result_valid_ff, conv_busy_ff, shutdown_ff, mid_sel_ff;
    logic       result_done_ff;
    logic [7:0] analog_channel_in, result_data_ff, last_result_ff;
    int         error_cnt = 0;
    int         checks_done = 0;

    always #2.5 clk_sys = ~clk_sys;

    acr_link_if u_acr_link_if ();
    // short conversion keeps the run small; host wait must stay above it
    acr_device #(.CONV_CYC(64)) u_acr_device (
        .clk_sys(clk_sys), .rst_n(rst_n), .link(u_acr_link_if),
        .analog_channel_in(analog_channel_in), .conv_busy_ff(conv_busy_ff),
        .shutdown_ff(shutdown_ff), .mid_sel_ff(mid_sel_ff),
        .result_done_ff(result_done_ff), .last_result_ff(last_result_ff));
    acr_host #(.WAIT_CYC(80)) u_acr_host (
        .clk_sys(clk_sys), .rst_n(rst_n), .link(u_acr_link_if), .start(start),
        .start_mid(start_mid), .clk_idle_high(clk_idle_high), .busy_ff(busy_ff),
        .result_valid_ff(result_valid_ff), .result_ready(result_ready),
        .result_data_ff(result_data_ff));
    acr_link_properties u_acr_link_properties (
        .clk_sys(clk_sys), .rst_n(rst_n), .convert_start_n(u_acr_link_if.convert_start_n),
        .sclk(u_acr_link_if.sclk), .dout_o(u_acr_link_if.dout_o),
        .dout_oe(u_acr_link_if.dout_oe), .dout_line(u_acr_link_if.dout_line));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic wait_lvl(input string what, ref logic sig, input logic lvl);
        int n;
        n = 0;
        while (sig !== lvl && n < 4000) begin
            @(negedge clk_sys);
            n++;
        end
        if (sig !== lvl) begin
            error_cnt++;
            $display("mismatch %s expected %b seen %b", what, lvl, sig);
            give_verdict();
        end
    endtask

    task automatic issue(input logic [7:0] code, input logic mid);
        @(negedge clk_sys);
        analog_channel_in = code;
        start_mid = mid;
        start = 1'b1;
        wait_lvl("busy_ff", busy_ff, 1'b1);
        start = 1'b0;
    endtask

    task automatic pop(input logic [7:0] exp);
        wait_lvl("result_valid_ff", result_valid_ff, 1'b1);
        `TB_CHK("result_data_ff", exp, result_data_ff)
        result_ready = 1'b1;
        @(negedge clk_sys);
        result_ready = 1'b0;
    endtask

    task automatic t_reset_state();
        `TB_CHK("shutdown_ff", 1'b1, shutdown_ff)
        `TB_CHK("dout_line", 1'b1, u_acr_link_if.dout_line)
    endtask

    // both shift clock idle levels, channel and mid-supply, code extremes
    task automatic t_modes();
        logic [7:0] codes [4] = '{8'h00, 8'hff, 8'h5a, 8'ha5};
        logic [7:0] exp;
        for (int i = 0; i < 4; i++) begin
            @(negedge clk_sys);
            clk_idle_high = i[0];
            exp = i[1] ? 8'h80 : codes[i];
            issue(codes[i], i[1]);
            // analog part is powered only while the conversion runs
            wait_lvl("conv_busy_ff", conv_busy_ff, 1'b1);
            `TB_CHK("shutdown_ff", 1'b0, shutdown_ff)
            // completion pulse stands in the first cycle after busy drops
            wait_lvl("conv_busy_ff", conv_busy_ff, 1'b0);
            `TB_CHK("result_done_ff", 1'b1, result_done_ff)
            pop(exp);
            wait_lvl("busy_ff", busy_ff, 1'b0);
            `TB_CHK("mid_sel_ff", i[1], mid_sel_ff)
            `TB_CHK("shutdown_ff", 1'b1, shutdown_ff)
            `TB_CHK("last_result_ff", exp, last_result_ff)
        end
    endtask

    // receiver stalls: buffer fills, a third start waits, nothing is lost
    task automatic t_stall();
        issue(8'h11, 1'b0);
        wait_lvl("busy_ff", busy_ff, 1'b0);
        issue(8'h22, 1'b0);
        wait_lvl("busy_ff", busy_ff, 1'b0);
        @(negedge clk_sys);
        analog_channel_in = 8'h33;
        start = 1'b1;
        repeat (60) @(negedge clk_sys);
        `TB_CHK("busy_ff", 1'b0, busy_ff)
        pop(8'h11);
        wait_lvl("busy_ff", busy_ff, 1'b1);
        start = 1'b0;
        pop(8'h22);
        pop(8'h33);
        `TB_CHK("last_result_ff", 8'h33, last_result_ff)
    endtask

    initial begin
        rst_n = 1'b0;
        start = 1'b0;
        start_mid = 1'b0;
        clk_idle_high = 1'b0;
        result_ready = 1'b0;
        analog_channel_in = 8'h00;
        repeat (3) @(negedge clk_sys);
        rst_n = 1'b1;
        @(negedge clk_sys);
        t_reset_state();
        t_modes();
        t_stall();
        give_verdict();
    end
endmodule
